// ==== strap_decoder_defines.svh ====
// How it works
// - Fault strap high and width strap high select 8-bit expanded mode.
// - 8-bit mode: low data byte is port H, high byte data, addr 18..3 bus.
// - 8-bit mode: addr 23..19 are chip selects, addr 2..0 address, no emulation.
// - Handshake strap low moves acknowledge, strobe and size pins to port E.
// - Interrupt strap low moves interrupt pins and clock-mode pin to port F.
// - 8-bit mode: boot select 8-bit; port E and F selects follow the straps as in 16-bit mode.
// - Fault strap low selects single-chip mode; tying it low is valid.
// - Single-chip: data pins are ports G,H; addr 18..3 ports A,B; no data bus.
// - Single-chip ignores expanded straps; ports A,B,C,E,F,G,H always selected.
// - Single-chip: low address disable set by reset; clearing it enables pins.
// - Single-chip: boot select 16-bit; code/select pins port C; irq 7,6 port F.
// - Clock strap high uses synthesizer; low uses external clock.
// - Breakpoint low at reset release enables background debug mode.
// - Breakpoint high at reset release disables debug; breakpoints become exceptions.
// - Debug enable relatched at every reset release, held until next reset.
// - Fault strap high and width strap low select 16-bit expanded mode.
`ifndef STRAP_DECODER_DEFINES_SVH
`define STRAP_DECODER_DEFINES_SVH

// ---------------------------------------------------------------
// Reset values and synchroniser depth
// ---------------------------------------------------------------
`define LOW_ADDR_DISABLE_RESET 1'b1
`define SYNC_STAGES 2

`endif

// ==== strap_decoder_pkg.sv ====
package strap_decoder_pkg;

	// -----------------------------------------------------------
	// Types
	// -----------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_SINGLE_CHIP,
		MODE_EXPANDED_8,
		MODE_EXPANDED_16
	} op_mode_t;

	typedef struct packed {
		logic bus_fault_strap;
		logic bus_width_strap;
		logic handshake_pin_strap;
		logic irq_pin_strap;
		logic clock_source_strap;
		logic breakpoint_pin;
	} strap_pins_t;

	typedef struct packed {
		op_mode_t mode;
		logic port_h_low_data;
		logic port_g_high_data;
		logic ports_ab_addr;
		logic ext_data_bus;
		logic addr_hi_chip_selects;
		logic addr_low_enable;
		logic port_e_sel;
		logic port_f_sel;
		logic port_c_sel;
		logic boot_cs_16bit;
		logic emulation_en;
		logic clock_synth_en;
		logic background_debug_mode;
	} pin_config_t;

	typedef struct packed {
		strap_pins_t sync1;
		strap_pins_t sync2;
		logic in_reset;
		logic low_addr_disable_bit;
		pin_config_t cfg;
	} decoder_state_t;

endpackage

// ==== reset_mode_strap_decoder.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "strap_decoder_defines.svh"

module reset_mode_strap_decoder (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Strap pins, asynchronous
	input wire strap_decoder_pkg::strap_pins_t straps_in,
	// Software control of the low address pins
	input wire logic low_addr_disable_clr_in,
	input wire logic low_addr_disable_set_in,
	// Breakpoint sources after reset
	input wire logic internal_breakpoint_in,
	// Latched configuration
	output strap_decoder_pkg::pin_config_t config_out,
	output logic low_addr_disable_bit_out,
	output logic low_addr_pins_hiz_out,
	// Breakpoint routing
	output logic enter_debug_out,
	output logic breakpoint_exception_out
);
	import strap_decoder_pkg::*;

	decoder_state_t s_q;
	decoder_state_t s_d;
	pin_config_t dec;
	logic breakpoint_pin_event;

	// ---------------------------------------------------------------
	// Strap decode from synchronised levels
	// ---------------------------------------------------------------
	// Evaluated every cycle; only the value at reset release is kept
	always_comb begin
		dec = '0;
		dec.clock_synth_en = s_q.sync2.clock_source_strap;
		dec.background_debug_mode = ~s_q.sync2.breakpoint_pin;
		if (!s_q.sync2.bus_fault_strap) begin
			// Single-chip ignores the expanded straps entirely
			dec.mode = MODE_SINGLE_CHIP;
			dec.port_h_low_data = 1'b1;
			dec.port_g_high_data = 1'b1;
			dec.ports_ab_addr = 1'b1;
			dec.ext_data_bus = 1'b0;
			dec.port_c_sel = 1'b1;
			dec.port_e_sel = 1'b1;
			dec.port_f_sel = 1'b1;
			dec.boot_cs_16bit = 1'b1;
			dec.addr_low_enable = 1'b0;
		end else if (s_q.sync2.bus_width_strap) begin
			dec.mode = MODE_EXPANDED_8;
			dec.port_h_low_data = 1'b1;
			dec.ext_data_bus = 1'b1;
			dec.addr_hi_chip_selects = 1'b1;
			dec.addr_low_enable = 1'b1;
			dec.emulation_en = 1'b0;
			dec.boot_cs_16bit = 1'b0;
			dec.port_e_sel = ~s_q.sync2.handshake_pin_strap;
			dec.port_f_sel = ~s_q.sync2.irq_pin_strap;
		end else begin
			dec.mode = MODE_EXPANDED_16;
			dec.ext_data_bus = 1'b1;
			dec.addr_low_enable = 1'b1;
			dec.boot_cs_16bit = 1'b1;
			dec.port_e_sel = ~s_q.sync2.handshake_pin_strap;
			dec.port_f_sel = ~s_q.sync2.irq_pin_strap;
		end
	end

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.sync1 = straps_in;
		s_d.sync2 = s_q.sync1;
		s_d.in_reset = 1'b0;
		if (s_q.in_reset) begin
			// First cycle after release: capture and freeze
			s_d.cfg = dec;
			s_d.low_addr_disable_bit = `LOW_ADDR_DISABLE_RESET;
		end else if (low_addr_disable_set_in) begin
			s_d.low_addr_disable_bit = 1'b1;
		end else if (low_addr_disable_clr_in) begin
			s_d.low_addr_disable_bit = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	// Synchronisers keep running in reset so straps settle before release
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			s_q.sync1 <= s_d.sync1;
			s_q.sync2 <= s_d.sync2;
			s_q.in_reset <= 1'b1;
			s_q.low_addr_disable_bit <= `LOW_ADDR_DISABLE_RESET;
			s_q.cfg <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign breakpoint_pin_event = ~s_q.sync2.breakpoint_pin | internal_breakpoint_in;
	assign config_out = s_q.cfg;
	assign low_addr_disable_bit_out = s_q.low_addr_disable_bit;
	// Only single-chip honours the disable bit
	assign low_addr_pins_hiz_out = (s_q.cfg.mode == MODE_SINGLE_CHIP)
		& s_q.low_addr_disable_bit;
	assign enter_debug_out = ~s_q.in_reset & breakpoint_pin_event
		& s_q.cfg.background_debug_mode;
	assign breakpoint_exception_out = ~s_q.in_reset & breakpoint_pin_event
		& ~s_q.cfg.background_debug_mode;

endmodule
`default_nettype wire

// ==== decoder_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module decoder_asserts import strap_decoder_pkg::*; (
	// Watched design ports
	input wire logic clk_sys_in, rst_in, low_addr_disable_bit_out,
	input wire logic low_addr_pins_hiz_out, input wire strap_pins_t straps_in,
	input wire pin_config_t config_out);
	strap_pins_t s1_q, s2_q, s;
	wire pin_config_t c = config_out;
	wire logic hz = !s.bus_fault_strap;
	// Strap history; pins stay still through the end of reset
	always_ff @(posedge clk_sys_in) {s, s2_q, s1_q} <= {s2_q, s1_q, straps_in};
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// Load edge: first edge with reset low
	sequence rel_s; $past(rst_in) && !rst_in; endsequence
	chk_mode_pick: assert property (rel_s |=> c.mode ==
		(hz ? MODE_SINGLE_CHIP : s.bus_width_strap ? MODE_EXPANDED_8 :
		MODE_EXPANDED_16)) else $error("mode wrong");
	chk_port_e: assert property (rel_s |=>
		c.port_e_sel == (hz || !s.handshake_pin_strap)) else $error("port e");
	chk_port_f: assert property (rel_s |=>
		c.port_f_sel == (hz || !s.irq_pin_strap)) else $error("port f");
	chk_clock_src: assert property (rel_s |=>
		c.clock_synth_en == s.clock_source_strap) else $error("clock");
	chk_debug_en: assert property (rel_s |=>
		c.background_debug_mode == !s.breakpoint_pin) else $error("debug");
	chk_no_bus: assert property (rel_s ##1 hz |->
		!c.ext_data_bus && c.ports_ab_addr) else $error("single bus");
	chk_cfg_hold: assert property (!$past(rst_in, 2) &&
		!$past(rst_in) |-> $stable(c)) else $error("config drift");
	chk_low_addr: assert property (rel_s |-> low_addr_disable_bit_out
		##1 low_addr_pins_hiz_out == hz) else $error("low addr");
endmodule
bind reset_mode_strap_decoder decoder_asserts u_decoder_asserts (.*);
`default_nettype wire

// ==== strap_board_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module strap_board_model import strap_decoder_pkg::*; (
	// Clock, reset, wanted levels and the strap pins
	input wire logic clk_sys_in, rst_in, input wire strap_pins_t want_in,
	output var strap_pins_t straps_out);
	// Driven hard in reset; later the pins carry traffic, breakpoint let go
	always @(negedge clk_sys_in)
		straps_out <= rst_in ? want_in : {~straps_out[5:1], 1'b1};
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	n_errors++; $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module tb_top;
	import strap_decoder_pkg::*;
	logic clk_sys_in = 0, rst_in = 1, ibp = 0, clr = 0, set = 0, hiz, dbg, exc;
	logic [8:0] e, q[$];
	strap_pins_t w = '0, straps;
	pin_config_t cfg;
	int n_errors = 0, total_checks = 0;
	// Clock, board and device
	always #5 clk_sys_in = ~clk_sys_in;
	strap_board_model u_strap_board_model (.clk_sys_in, .rst_in,
		.want_in(w), .straps_out(straps));
	reset_mode_strap_decoder u_reset_mode_strap_decoder (.clk_sys_in, .rst_in,
		.straps_in(straps), .low_addr_disable_clr_in(clr),
		.low_addr_disable_set_in(set), .internal_breakpoint_in(ibp),
		.config_out(cfg), .low_addr_disable_bit_out(),
		.low_addr_pins_hiz_out(hiz), .enter_debug_out(dbg),
		.breakpoint_exception_out(exc));
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Monitor: oldest note against the outputs, just after each edge
	always @(posedge clk_sys_in) if (q.size() > 0) begin
		#1;
		`CHK({cfg.mode, hiz, dbg, exc,
			cfg.port_e_sel, cfg.port_f_sel, cfg.clock_synth_en,
			cfg.background_debug_mode}, q.pop_front())
	end
	// Random straps over repeated resets; straps toggle after release
	initial begin
		void'($urandom(32'h0521));
		fork
			repeat (16) begin
				{rst_in, ibp, set, clr} <= 4'b1000;
				w <= strap_pins_t'(6'($urandom));
				repeat (5) @(negedge clk_sys_in);
				rst_in <= 0;
				repeat (4) @(negedge clk_sys_in);
				e[8:7] = !w.bus_fault_strap ? MODE_SINGLE_CHIP :
					w.bus_width_strap ? MODE_EXPANDED_8 : MODE_EXPANDED_16;
				e[6:0] = {!w.bus_fault_strap, 2'b00, !(w.handshake_pin_strap &&
					w.bus_fault_strap), !(w.irq_pin_strap && w.bus_fault_strap),
					w.clock_source_strap, !w.breakpoint_pin};
				q.push_back(e);
				@(negedge clk_sys_in);
				{ibp, clr} <= 2'b11;
				q.push_back({e[8:7], 1'b0, e[0], !e[0], e[3:0]});
				@(negedge clk_sys_in);
				// Set and clear together: set must win
				{ibp, set} <= 2'b01;
				q.push_back({e[8:7], e[6], 2'b00, e[3:0]});
				@(negedge clk_sys_in);
			end
			#6000 n_errors++;
		join_any
		give_verdict();
	end
endmodule
`default_nettype wire
